// ---- rtl/dacf_control.sv ----
`timescale 1ns/1ps
// How it works
// R01: Enable clear: output off, converter shut down
// R02: Enable set: output driven, converter running
// R03: Control bits 6:5 read zero, ignore writes
// R04: Mode 00: latch updates on high-byte write
// R05: Mode 01: latch updates on timer 3 overflow
// R06: Mode 10: latch updates on timer 4 overflow
// R07: Mode 11: latch updates on timer 2 overflow
// R08: Format 000: high[3:0] then whole low byte
// R09: Format 001: high[4:0] then low[7:1]
// R10: Format 010: high[5:0] then low[7:2]
// R11: Format 011: high[6:0] then low[7:3]
// R12: Format 1xx: whole high then low[7:4]
// R13: Mode 00: low write held until high write
// R14: Timer modes: both bytes held until overflow
// R15: Low-byte read returns last written value
// R16: High-byte read returns high input latch
// R17: Reset clears holds, latches and control
module dacf_control (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   output logic [7:0] sfr_rdata,
   input wire logic timer2_overflow,
   input wire logic timer3_overflow,
   input wire logic timer4_overflow,
   output logic [11:0] converter_code,
   output logic converter_output_enable,
   output logic converter_shutdown
);

   // ============================================================
   // Decoded write strobes
   logic write_low;
   logic write_high;
   logic write_control;

   assign write_low = sfr_wr && (sfr_addr == dacf_pkg::ADDR_LOW_BYTE);
   assign write_high = sfr_wr && (sfr_addr == dacf_pkg::ADDR_HIGH_BYTE);
   assign write_control = sfr_wr && (sfr_addr == dacf_pkg::ADDR_CONTROL);

   // ============================================================
   // Control register
   logic [7:0] control_reg;
   logic [7:0] control_next;
   logic converter_enable;
   logic [1:0] update_mode_field;
   logic [2:0] data_format_field;

   always_comb begin
      control_next = control_reg;
      if (write_control) begin
         control_next = sfr_wdata & dacf_pkg::CTRL_WRITE_MASK; // see R03
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         control_reg <= dacf_pkg::RESET_CONTROL; // see R17
      end else begin
         control_reg <= control_next;
      end
   end

   assign converter_enable = control_reg[dacf_pkg::CTRL_ENABLE_BIT];
   assign update_mode_field = control_reg[dacf_pkg::CTRL_MODE_MSB:dacf_pkg::CTRL_MODE_LSB];
   assign data_format_field =
      control_reg[dacf_pkg::CTRL_FORMAT_MSB:dacf_pkg::CTRL_FORMAT_LSB];

   // ============================================================
   // Holding registers: what software last wrote
   logic [7:0] low_hold_reg;
   logic [7:0] low_hold_next;
   logic [7:0] high_hold_reg;
   logic [7:0] high_hold_next;

   always_comb begin
      low_hold_next = low_hold_reg;
      high_hold_next = high_hold_reg;
      if (write_low) begin
         low_hold_next = sfr_wdata; // see R13, R14
      end
      if (write_high) begin
         high_hold_next = sfr_wdata; // see R14
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         low_hold_reg <= dacf_pkg::RESET_LOW_BYTE; // see R17
         high_hold_reg <= dacf_pkg::RESET_HIGH_BYTE; // see R17
      end else begin
         low_hold_reg <= low_hold_next;
         high_hold_reg <= high_hold_next;
      end
   end

   // ============================================================
   // Update event selection
   logic update_event;

   always_comb begin
      unique case (update_mode_field)
         dacf_pkg::MODE_ON_HIGH_WRITE: begin
            update_event = write_high; // see R04
         end
         dacf_pkg::MODE_TIMER3: begin
            update_event = timer3_overflow; // see R05
         end
         dacf_pkg::MODE_TIMER4: begin
            update_event = timer4_overflow; // see R06
         end
         dacf_pkg::MODE_TIMER2: begin
            update_event = timer2_overflow; // see R07
         end
      endcase
   end

   // ============================================================
   // Converter input latches
   // The hold values of this very cycle are copied, so a write that
   // meets an overflow in the same cycle is not left behind.
   logic [7:0] low_latch_reg;
   logic [7:0] low_latch_next;
   logic [7:0] high_latch_reg;
   logic [7:0] high_latch_next;

   always_comb begin
      low_latch_next = low_latch_reg;
      high_latch_next = high_latch_reg;
      if (update_event) begin
         low_latch_next = low_hold_next; // see R13, R14
         high_latch_next = high_hold_next; // see R04, R14
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         low_latch_reg <= dacf_pkg::RESET_LOW_BYTE; // see R17
         high_latch_reg <= dacf_pkg::RESET_HIGH_BYTE; // see R17
      end else begin
         low_latch_reg <= low_latch_next;
         high_latch_reg <= high_latch_next;
      end
   end

   // ============================================================
   // Word justification
   dacf_word_if word_bus ();

   assign word_bus.high_byte = high_latch_reg;
   assign word_bus.low_byte = low_latch_reg;
   assign word_bus.format = data_format_field;

   dacf_formatter u_formatter (
      .word_bus(word_bus.formatter)
   );

   // ============================================================
   // Converter-facing outputs
   // Registered so the analog side sees clean edges; costs one cycle.
   logic [11:0] code_reg;
   logic [11:0] code_next;
   logic output_enable_reg;
   logic output_enable_next;
   logic shutdown_reg;
   logic shutdown_next;

   always_comb begin
      code_next = word_bus.word;
      output_enable_next = converter_enable; // see R01, R02
      shutdown_next = !converter_enable; // see R01, R02
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         code_reg <= dacf_pkg::RESET_CODE; // see R17
         output_enable_reg <= 1'h0;
         shutdown_reg <= 1'h1;
      end else begin
         code_reg <= code_next;
         output_enable_reg <= output_enable_next;
         shutdown_reg <= shutdown_next;
      end
   end

   assign converter_code = code_reg;
   assign converter_output_enable = output_enable_reg;
   assign converter_shutdown = shutdown_reg;

   // ============================================================
   // Read data, one cycle after the address
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   always_comb begin
      unique case (sfr_addr)
         dacf_pkg::ADDR_LOW_BYTE: begin
            rdata_next = low_hold_reg; // see R15
         end
         dacf_pkg::ADDR_HIGH_BYTE: begin
            rdata_next = high_latch_reg; // see R16
         end
         dacf_pkg::ADDR_CONTROL: begin
            rdata_next = control_reg; // see R03
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;

endmodule : dacf_control

// ---- rtl/dacf_pkg.sv ----
// ============================================================
// Shared constants of the second converter control block
package dacf_pkg;

   // ============================================================
   // Register map
   localparam logic [7:0] ADDR_LOW_BYTE = 8'hD5;
   localparam logic [7:0] ADDR_HIGH_BYTE = 8'hD6;
   localparam logic [7:0] ADDR_CONTROL = 8'hD7;

   // ============================================================
   // Control field layout
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_MODE_LSB = 3;
   localparam int CTRL_MODE_MSB = 4;
   localparam int CTRL_FORMAT_LSB = 0;
   localparam int CTRL_FORMAT_MSB = 2;
   // Writable bits; bits 6 and 5 read back as zero
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h9F;

   // ============================================================
   // Update mode codes
   localparam logic [1:0] MODE_ON_HIGH_WRITE = 2'h0;
   localparam logic [1:0] MODE_TIMER3 = 2'h1;
   localparam logic [1:0] MODE_TIMER4 = 2'h2;
   localparam logic [1:0] MODE_TIMER2 = 2'h3;

   // ============================================================
   // Data format codes (any code with bit 2 set is the 8:4 split)
   localparam logic [2:0] FORMAT_4_8 = 3'h0;
   localparam logic [2:0] FORMAT_5_7 = 3'h1;
   localparam logic [2:0] FORMAT_6_6 = 3'h2;
   localparam logic [2:0] FORMAT_7_5 = 3'h3;

   // ============================================================
   // Reset values
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_LOW_BYTE = 8'h00;
   localparam logic [7:0] RESET_HIGH_BYTE = 8'h00;
   localparam logic [11:0] RESET_CODE = 12'h000;

endpackage : dacf_pkg

// ---- rtl/dacf_word_if.sv ----
`timescale 1ns/1ps
// ============================================================
// Latched bytes and format going to the word formatter
interface dacf_word_if;
   logic [7:0] high_byte;
   logic [7:0] low_byte;
   logic [2:0] format;
   logic [11:0] word;

   modport source (
      output high_byte,
      output low_byte,
      output format,
      input word
   );

   modport formatter (
      input high_byte,
      input low_byte,
      input format,
      output word
   );
endinterface : dacf_word_if

// ---- rtl/dacf_formatter.sv ----
`timescale 1ns/1ps
// ============================================================
// Justifies the 12-bit word out of the two latched bytes
module dacf_formatter (
   dacf_word_if.formatter word_bus
);

   always_comb begin
      if (word_bus.format[2]) begin
         word_bus.word = {word_bus.high_byte, word_bus.low_byte[7:4]}; // see R12
      end else begin
         unique case (word_bus.format)
            dacf_pkg::FORMAT_4_8: begin
               word_bus.word = {word_bus.high_byte[3:0], word_bus.low_byte}; // see R08
            end
            dacf_pkg::FORMAT_5_7: begin
               word_bus.word = {word_bus.high_byte[4:0], word_bus.low_byte[7:1]}; // see R09
            end
            dacf_pkg::FORMAT_6_6: begin
               word_bus.word = {word_bus.high_byte[5:0], word_bus.low_byte[7:2]}; // see R10
            end
            default: begin
               word_bus.word = {word_bus.high_byte[6:0], word_bus.low_byte[7:3]}; // see R11
            end
         endcase
      end
   end

endmodule : dacf_formatter

// ---- verif/dacf_monitor.sv ----
`timescale 1ns/1ps
// ==========
// Port checker
module dacf_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer2_overflow,
   input wire logic timer3_overflow,
   input wire logic timer4_overflow,
   input wire logic [11:0] converter_code,
   input wire logic converter_output_enable,
   input wire logic converter_shutdown
);
   localparam logic [7:0] AL = dacf_pkg::ADDR_LOW_BYTE;
   localparam logic [7:0] AH = dacf_pkg::ADDR_HIGH_BYTE;
   localparam logic [7:0] AC = dacf_pkg::ADDR_CONTROL;
   logic [4:0] ctl_q;
   logic [7:0] hi_h, lo_h, lat_h, hi_n, lo_n;
   logic [11:0] want;
   logic upd, wc;
   function automatic logic [11:0] fmt(input logic [7:0] h, input logic [7:0] l,
                                       input logic [2:0] f);
      if (f[2]) return {h, l[7:4]};
      case (f[1:0])
         2'h0: return {h[3:0], l};
         2'h1: return {h[4:0], l[7:1]};
         2'h2: return {h[5:0], l[7:2]};
         default: return {h[6:0], l[7:3]};
      endcase
   endfunction : fmt
   always_comb begin
      wc = sfr_wr && sfr_addr == AC;
      hi_n = (sfr_wr && sfr_addr == AH) ? sfr_wdata : hi_h;
      lo_n = (sfr_wr && sfr_addr == AL) ? sfr_wdata : lo_h;
      upd = (ctl_q[4:3] == 2'h0 && sfr_wr && sfr_addr == AH) ||
            (ctl_q[4:3] == 2'h1 && timer3_overflow) ||
            (ctl_q[4:3] == 2'h2 && timer4_overflow) ||
            (ctl_q[4:3] == 2'h3 && timer2_overflow);
      want = fmt(hi_n, lo_n, wc ? sfr_wdata[2:0] : ctl_q[2:0]);
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl_q <= 5'h00;
         hi_h <= 8'h00;
         lo_h <= 8'h00;
         lat_h <= 8'h00;
      end else begin
         ctl_q <= wc ? sfr_wdata[4:0] : ctl_q;
         hi_h <= hi_n;
         lo_h <= lo_n;
         lat_h <= upd ? hi_n : lat_h;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_enable_out: assert property (wc |-> ##2
      converter_output_enable == $past(sfr_wdata[7], 2))
      else $error("output enable does not follow control bit");
   a_shutdown_inverse: assert property (
      converter_shutdown == !converter_output_enable)
      else $error("shutdown not inverse of enable");
   a_ctrl_unused: assert property (sfr_addr == AC |=> sfr_rdata[6:5] == 2'h0)
      else $error("unused control bits read nonzero");
   a_word_update: assert property (upd |-> ##2
      converter_code == $past(want, 2))
      else $error("converter word wrong after update");
   a_no_spurious: assert property ($changed(converter_code) |-> $past(upd || wc, 2))
      else $error("converter word changed without update");
   a_low_readback: assert property (sfr_addr == AL |=> sfr_rdata == $past(lo_h))
      else $error("low byte read wrong");
   a_high_readback: assert property (sfr_addr == AH |=> sfr_rdata == $past(lat_h))
      else $error("high byte read not latch");
   a_reset_clear: assert property ($past(rst) |->
      converter_code == 12'h000 && sfr_rdata == 8'h00)
      else $error("state not cleared by reset");
   c_high_write: cover property (ctl_q[4:3] == 2'h0 && sfr_wr && sfr_addr == AH);
   c_timer3: cover property (ctl_q[4:3] == 2'h1 && timer3_overflow);
   c_timer4: cover property (ctl_q[4:3] == 2'h2 && timer4_overflow);
   c_timer2: cover property (ctl_q[4:3] == 2'h3 && timer2_overflow);
endmodule : dacf_monitor
bind dacf_control dacf_monitor mon (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
   .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
   .timer4_overflow(timer4_overflow), .converter_code(converter_code),
   .converter_output_enable(converter_output_enable), .converter_shutdown(converter_shutdown));

// ---- verif/dacf_core_model.sv ----
`timescale 1ns/1ps
// ==========
// Processor core on the register bus
module dacf_core_model (
   input wire logic sys_clk,
   input wire logic [7:0] sfr_rdata,
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic sfr_wr
);
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'h0;
   end
   // Two cycles per write so the strobe never rises in the step it falls
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'h1;
      @(negedge sys_clk);
      sfr_wr = 1'h0;
      sfr_wdata = ~d;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      @(negedge sys_clk);
      d = sfr_rdata;
   endtask : read_reg
endmodule : dacf_core_model

// ---- verif/test_dac_update_format_control.sv ----
`timescale 1ns/1ps
// ==========
// Register-level bench
module test_dac_update_format_control;
   localparam logic [7:0] AL = dacf_pkg::ADDR_LOW_BYTE;
   localparam logic [7:0] AH = dacf_pkg::ADDR_HIGH_BYTE;
   localparam logic [7:0] AC = dacf_pkg::ADDR_CONTROL;
   logic sys_clk, rst, t2, t3, t4, sfr_wr, oe, sd;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, ph, pl, hi, lo;
   logic [11:0] code;
   logic [2:0] tv;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   dacf_control dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .timer2_overflow(t2), .timer3_overflow(t3),
      .timer4_overflow(t4), .converter_code(code), .converter_output_enable(oe),
      .converter_shutdown(sd));
   dacf_core_model core (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   function automatic logic [11:0] word(input logic [7:0] h, input logic [7:0] l,
                                        input logic [2:0] f);
      case (f)
         3'h0: return {h[3:0], l};
         3'h1: return {h[4:0], l[7:1]};
         3'h2: return {h[5:0], l[7:2]};
         3'h3: return {h[6:0], l[7:3]};
         default: return {h, l[7:4]};
      endcase
   endfunction : word
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      core.read_reg(a, rd);
      check({4'h0, rd}, {4'h0, e});
   endtask : rd_chk
   task automatic code_chk(input logic [11:0] e);
      @(negedge sys_clk);
      check(code, e);
   endtask : code_chk
   // Timer pulse vector is {timer4, timer3, timer2}
   task automatic pulse(input logic [2:0] v);
      @(negedge sys_clk);
      {t4, t3, t2} = v;
      @(negedge sys_clk);
      {t4, t3, t2} = 3'h0;
   endtask : pulse
   task automatic tally_and_finish;
      $display("errors=%0d checks=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      {t4, t3, t2} = 3'h0;
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      rd_chk(AL, 8'h00);
      rd_chk(AH, 8'h00);
      rd_chk(AC, 8'h00);
      code_chk(12'h000);
      check({10'h0, oe, sd}, 12'h001);
      core.write_reg(AC, 8'hFF);
      rd_chk(AC, 8'h9F);
      check({10'h0, oe, sd}, 12'h002);
      ph = 8'h00;
      pl = 8'h00;
      for (int f = 0; f < 8; f++) begin
         hi = 8'hE6 ^ f[7:0];
         lo = 8'h9D + 8'h11 * f[7:0];
         core.write_reg(AC, 8'h80 | f[7:0]);
         code_chk(word(ph, pl, f[2:0]));
         core.write_reg(AL, lo);
         code_chk(word(ph, pl, f[2:0]));
         core.write_reg(AH, hi);
         code_chk(word(hi, lo, f[2:0]));
         rd_chk(AL, lo);
         ph = hi;
         pl = lo;
      end
      for (int m = 1; m < 4; m++) begin
         tv = (m == 1) ? 3'h2 : (m == 2) ? 3'h4 : 3'h1;
         hi = 8'h30 + m[7:0];
         lo = 8'hC0 + m[7:0];
         core.write_reg(AC, 8'h87 | {m[4:0], 3'h0});
         core.write_reg(AL, lo);
         core.write_reg(AH, hi);
         code_chk(word(ph, pl, 3'h7));
         rd_chk(AH, ph);
         rd_chk(AL, lo);
         pulse(~tv);
         code_chk(word(ph, pl, 3'h7));
         pulse(tv);
         code_chk(word(hi, lo, 3'h7));
         rd_chk(AH, hi);
         ph = hi;
         pl = lo;
      end
      core.write_reg(AC, 8'h00);
      @(negedge sys_clk);
      check({10'h0, oe, sd}, 12'h001);
      rd_chk(8'hD8, 8'h00);
      tally_and_finish();
   end
endmodule : test_dac_update_format_control
